// >>> rmcrt_defs.vh
`ifndef RMCRT_DEFS_VH
`define RMCRT_DEFS_VH
// Register indexes; byte address is four times the index
`define RMCRT_IDX_MODEM    18'h0_df0e
`define RMCRT_IDX_SPACING  18'h0_df10
`define RMCRT_IDX_DEVIATE  18'h0_df11
`define RMCRT_IDX_RXTIME   18'h0_df12
`define RMCRT_IDX_CHANNEL  18'h0_df20
`define RMCRT_IDX_EVENT    18'h0_df21
`define RMCRT_IDX_STATUS   18'h0_df22
// Reset values
`define RMCRT_RST_MODEM    8'h22
`define RMCRT_RST_SPACING  8'hf8
`define RMCRT_RST_DEVIATE  8'h47
`define RMCRT_RST_RXTIME   8'h07
`define RMCRT_RST_CHANNEL  8'h00
`define RMCRT_RST_EVENT_ZERO_PERIOD   16'h0800
`define RMCRT_RST_WAKERES  2'h0
// Field positions
`define RMCRT_FEC_BIT      7
`define RMCRT_PRE_HI       6
`define RMCRT_PRE_LO       4
`define RMCRT_SPE_HI       1
`define RMCRT_SPE_LO       0
`define RMCRT_DEVE_HI      6
`define RMCRT_DEVE_LO      4
`define RMCRT_DEVM_HI      2
`define RMCRT_DEVM_LO      0
`define RMCRT_CST_BIT      4
`define RMCRT_QUAL_BIT     3
`define RMCRT_RXT_HI       2
`define RMCRT_RXT_LO       0
`define RMCRT_EVW_HI       17
`define RMCRT_EVW_LO       16
// Timing counts and step bases
`define RMCRT_RXT_OFF      3'h7
`define RMCRT_ASK_SYMBOLS  4'h8
`define RMCRT_RXT_BASE     5'h03
`define RMCRT_SPC_BASE     9'h100
`define RMCRT_DEV_BASE     4'h8
`endif

// >>> rmcrt_top.v
`timescale 1ns/100ps
`include "rmcrt_defs.vh"
module rmcrt_top (
    input  wire        ref_clk,
    input  wire        arst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [19:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rcClock,
    input  wire        rxStart,
    input  wire        syncFound,
    input  wire        preambleQualityReached,
    input  wire        carrierSense,
    input  wire        symbolTick,
    input  wire        packetEnd,
    input  wire        askMode,
    input  wire        mskMode,
    output reg         payloadCodingEnable_r,
    output reg  [4:0]  preambleBytes_r,
    output reg  [19:0] channelStep_r,
    output reg  [10:0] deviationStep_r,
    output reg  [2:0]  phaseChangeFraction_r,
    output reg         rxActive_r,
    output reg         rxAbort_r
);
    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_SEARCH = 3'b010;
    localparam [2:0] ST_RECV   = 3'b100;

    reg         rstSync1_r;
    reg         rstSync2_r;
    wire        rstN;
    reg  [7:0]  modemCfg_r;
    reg  [7:0]  spacingMant_r;
    reg  [7:0]  deviateCfg_r;
    reg  [7:0]  rxTimeCfg_r;
    reg  [7:0]  channelNumber_r;
    reg  [15:0] eventZeroPeriod_r;
    reg  [1:0]  wakeResolution_r;
    reg         rcSync1_r;
    reg         rcSync2_r;
    reg         rcSync3_r;
    wire        rcEdge;
    reg  [11:0] preCnt_r;
    reg  [12:0] toCnt_r;
    reg  [3:0]  symCnt_r;
    reg         carrierSeen_r;
    reg         pqtSeen_r;
    reg         timedOut_r;
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg         abort_nxt;
    reg  [31:0] readData;
    reg         addrHit;
    wire [17:0] regIdx;
    wire        apbAccess;
    wire        apbWrite;
    wire [11:0] preMask;
    wire        preTick;
    wire        expire;
    wire        checkPass;
    wire        timeoutOn;
    wire [2:0]  rxCode;
    wire [15:0] shiftedEvent;
    wire        cstOn;
    wire        qualOn;

    // Reset release
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    assign rstN = rstSync2_r;

    // APB decode
    assign regIdx    = paddr[19:2];
    assign apbAccess = psel & penable & ~pready;
    assign apbWrite  = psel & penable & pready & pwrite & ~pslverr;

    always @* begin
        readData = 32'h0000_0000;
        addrHit  = 1'b1;
        case (regIdx)
            `RMCRT_IDX_MODEM: begin
                readData[7:0] = modemCfg_r;
            end
            `RMCRT_IDX_SPACING: begin
                readData[7:0] = spacingMant_r;
            end
            `RMCRT_IDX_DEVIATE: begin
                readData[7:0] = deviateCfg_r;
            end
            `RMCRT_IDX_RXTIME: begin
                readData[7:0] = rxTimeCfg_r;
            end
            `RMCRT_IDX_CHANNEL: begin
                readData[7:0] = channelNumber_r;
            end
            `RMCRT_IDX_EVENT: begin
                readData[17:0] = {wakeResolution_r, eventZeroPeriod_r};
            end
            `RMCRT_IDX_STATUS: begin
                readData[5:0] = {pqtSeen_r, carrierSeen_r, timedOut_r, state_r};
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (apbAccess) begin
            pready  <= 1'b1;
            pslverr <= ~addrHit;
            prdata  <= pwrite ? 32'h0000_0000 : readData;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Configuration registers; reserved bits never stored
    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            modemCfg_r        <= `RMCRT_RST_MODEM;
            spacingMant_r     <= `RMCRT_RST_SPACING;
            deviateCfg_r      <= `RMCRT_RST_DEVIATE;
            rxTimeCfg_r       <= `RMCRT_RST_RXTIME;
            channelNumber_r   <= `RMCRT_RST_CHANNEL;
            eventZeroPeriod_r <= `RMCRT_RST_EVENT_ZERO_PERIOD;
            wakeResolution_r  <= `RMCRT_RST_WAKERES;
        end else if (apbWrite) begin
            case (regIdx)
                `RMCRT_IDX_MODEM: begin
                    modemCfg_r <= pwdata[7:0] & 8'hf3;
                end
                `RMCRT_IDX_SPACING: begin
                    spacingMant_r <= pwdata[7:0];
                end
                `RMCRT_IDX_DEVIATE: begin
                    deviateCfg_r <= pwdata[7:0] & 8'h77;
                end
                `RMCRT_IDX_RXTIME: begin
                    rxTimeCfg_r <= pwdata[7:0] & 8'h1f;
                end
                `RMCRT_IDX_CHANNEL: begin
                    channelNumber_r <= pwdata[7:0];
                end
                `RMCRT_IDX_EVENT: begin
                    eventZeroPeriod_r <= pwdata[15:0];
                    wakeResolution_r  <= pwdata[`RMCRT_EVW_HI:`RMCRT_EVW_LO];
                end
                default: begin
                end
            endcase
        end
    end

    // Modem setting outputs
    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            payloadCodingEnable_r <= 1'b0;
            preambleBytes_r       <= 5'h04;
            channelStep_r         <= 20'h0_0000;
            deviationStep_r       <= 11'h000;
            phaseChangeFraction_r <= 3'h0;
        end else begin
            payloadCodingEnable_r <= modemCfg_r[`RMCRT_FEC_BIT];
            case (modemCfg_r[`RMCRT_PRE_HI:`RMCRT_PRE_LO])
                3'h0: preambleBytes_r <= 5'h02;
                3'h1: preambleBytes_r <= 5'h03;
                3'h2: preambleBytes_r <= 5'h04;
                3'h3: preambleBytes_r <= 5'h06;
                3'h4: preambleBytes_r <= 5'h08;
                3'h5: preambleBytes_r <= 5'h0c;
                3'h6: preambleBytes_r <= 5'h10;
                default: preambleBytes_r <= 5'h18;
            endcase
            channelStep_r <= ({3'h0, ({8'h00, (`RMCRT_SPC_BASE + {1'b0, spacingMant_r})}
                              * {9'h000, channelNumber_r})}
                              << modemCfg_r[`RMCRT_SPE_HI:`RMCRT_SPE_LO]);
            if (mskMode) begin
                deviationStep_r       <= 11'h000;
                phaseChangeFraction_r <= deviateCfg_r[`RMCRT_DEVM_HI:`RMCRT_DEVM_LO];
            end else begin
                deviationStep_r <= {7'h00, (`RMCRT_DEV_BASE
                                   | {1'b0, deviateCfg_r[`RMCRT_DEVM_HI:`RMCRT_DEVM_LO]})}
                                   << deviateCfg_r[`RMCRT_DEVE_HI:`RMCRT_DEVE_LO];
                phaseChangeFraction_r <= 3'h0;
            end
        end
    end

    // RC oscillator tick synchroniser
    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            rcSync1_r <= 1'b0;
            rcSync2_r <= 1'b0;
            rcSync3_r <= 1'b0;
        end else begin
            rcSync1_r <= rcClock;
            rcSync2_r <= rcSync1_r;
            rcSync3_r <= rcSync2_r;
        end
    end
    assign rcEdge = rcSync2_r & ~rcSync3_r;

    // Timeout: (event_zero_period >> (3+code)) units of 2^(4*res) RC periods
    assign rxCode       = rxTimeCfg_r[`RMCRT_RXT_HI:`RMCRT_RXT_LO];
    assign cstOn        = rxTimeCfg_r[`RMCRT_CST_BIT];
    assign qualOn       = rxTimeCfg_r[`RMCRT_QUAL_BIT];
    assign timeoutOn    = (rxCode != `RMCRT_RXT_OFF);
    assign shiftedEvent = eventZeroPeriod_r >> (`RMCRT_RXT_BASE + {2'b00, rxCode});
    assign preMask      = ~(12'hfff << {wakeResolution_r, 2'b00});
    assign preTick      = rcEdge & ((preCnt_r & preMask) == preMask);
    assign expire       = (state_r == ST_SEARCH) & timeoutOn & preTick
                          & (toCnt_r <= 13'h0001);
    assign checkPass    = syncFound | (qualOn & (pqtSeen_r | preambleQualityReached));

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            preCnt_r      <= 12'h000;
            toCnt_r       <= 13'h0000;
            symCnt_r      <= 4'h0;
            carrierSeen_r <= 1'b0;
            pqtSeen_r     <= 1'b0;
        end else if (state_r != ST_SEARCH || rxStart) begin
            preCnt_r      <= 12'h000;
            toCnt_r       <= shiftedEvent[12:0];
            symCnt_r      <= 4'h0;
            carrierSeen_r <= 1'b0;
            pqtSeen_r     <= 1'b0;
        end else begin
            if (rcEdge) begin
                preCnt_r <= preCnt_r + 12'h001;
            end
            if (preTick && toCnt_r != 13'h0000) begin
                toCnt_r <= toCnt_r - 13'h0001;
            end
            if (symbolTick && symCnt_r != `RMCRT_ASK_SYMBOLS) begin
                symCnt_r <= symCnt_r + 4'h1;
            end
            carrierSeen_r <= carrierSeen_r | carrierSense;
            pqtSeen_r     <= pqtSeen_r | preambleQualityReached;
        end
    end

    // Receive sequencing
    always @* begin
        state_nxt = state_r;
        abort_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (rxStart) begin
                    state_nxt = ST_SEARCH;
                end
            end
            ST_SEARCH: begin
                if (cstOn && askMode && symbolTick && !carrierSeen_r && !carrierSense
                    && symCnt_r == `RMCRT_ASK_SYMBOLS - 4'h1) begin
                    state_nxt = ST_IDLE;
                    abort_nxt = 1'b1;
                end else if (cstOn && !askMode && symbolTick && !carrierSense) begin
                    state_nxt = ST_IDLE;
                    abort_nxt = 1'b1;
                end else if (syncFound) begin
                    state_nxt = ST_RECV;
                end else if (expire) begin
                    if (checkPass) begin
                        state_nxt = ST_RECV;
                    end else begin
                        state_nxt = ST_IDLE;
                        abort_nxt = 1'b1;
                    end
                end
            end
            ST_RECV: begin
                if (packetEnd) begin
                    state_nxt = ST_IDLE;
                end else if (cstOn && symbolTick && !carrierSense) begin
                    state_nxt = ST_IDLE;
                    abort_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            state_r    <= ST_IDLE;
            rxActive_r <= 1'b0;
            rxAbort_r  <= 1'b0;
            timedOut_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            rxActive_r <= (state_nxt != ST_IDLE);
            rxAbort_r  <= abort_nxt;
            if (expire && !checkPass && !syncFound) begin
                timedOut_r <= 1'b1;
            end else if (rxStart && state_r == ST_IDLE) begin
                timedOut_r <= 1'b0;
            end
        end
    end
endmodule

// >>> rmcrt_checker.sv
`timescale 1ns/100ps
`include "rmcrt_defs.vh"
module rmcrt_checker (
    input wire        ref_clk,
    input wire        arst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [19:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        rxStart,
    input wire        packetEnd,
    input wire        mskMode,
    input wire        payloadCodingEnable_r,
    input wire [4:0]  preambleBytes_r,
    input wire [10:0] deviationStep_r,
    input wire        rxActive_r,
    input wire        rxAbort_r
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    chk_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_error_data: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused access returned data");
    chk_coding_write: assert property (pready && pwrite && !pslverr
        && paddr[19:2] == `RMCRT_IDX_MODEM |-> ##2 payloadCodingEnable_r == $past(pwdata[7], 2))
        else $error("coding enable not taken from write");
    chk_preamble_set: assert property (preambleBytes_r inside
        {5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18})
        else $error("preamble length off table");
    chk_msk_zero: assert property (mskMode [*2] |=> deviationStep_r == 11'h000)
        else $error("deviation kept under msk");
    chk_abort_pulse: assert property (rxAbort_r |=> !rxAbort_r)
        else $error("abort longer than a cycle");
    chk_abort_leave: assert property (rxAbort_r |-> !rxActive_r && $past(rxActive_r))
        else $error("abort without leaving receive");
    chk_start_search: assert property (rxStart && !rxActive_r |=> rxActive_r)
        else $error("start did not begin search");
    chk_packet_stop: assert property (rxActive_r && packetEnd |=> !rxActive_r)
        else $error("packet end did not stop receive");
endmodule

bind rmcrt_top rmcrt_checker chk (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rxStart, .packetEnd, .mskMode, .payloadCodingEnable_r,
    .preambleBytes_r, .deviationStep_r, .rxActive_r, .rxAbort_r);

// >>> rmcrt_top_test.sv
`timescale 1ns/100ps
`include "rmcrt_defs.vh"
module rmcrt_top_test;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [19:0] paddr = 20'h0_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        rxStart = 1'b0, syncFound = 1'b0, preambleQualityReached = 1'b0;
    logic        carrierSense = 1'b0, symbolTick = 1'b0, packetEnd = 1'b0;
    logic        askMode = 1'b0, mskMode = 1'b0;
    logic [1:0]  rcDiv = 2'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, payloadCodingEnable_r, rxActive_r, rxAbort_r;
    wire  [4:0]  preambleBytes_r;
    wire  [19:0] channelStep_r;
    wire  [10:0] deviationStep_r;
    wire  [2:0]  phaseChangeFraction_r;
    int          numErrors = 0, checks = 0, cycles = 0, aborts = 0, n, a;
    logic [31:0] rd;
    logic        err;

    always #20 ref_clk = ~ref_clk;

    // Free running slow oscillator, one rising edge every four cycles
    always @(posedge ref_clk) begin
        rcDiv <= rcDiv + 2'h1;
        cycles <= cycles + 1;
        if (rxAbort_r === 1'b1)
            aborts <= aborts + 1;
        if (cycles == 20000) begin
            numErrors++;
            endOfTest;
        end
    end

    rmcrt_top dut (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .rcClock(rcDiv[1]), .rxStart, .syncFound, .preambleQualityReached,
        .carrierSense, .symbolTick, .packetEnd, .askMode, .mskMode, .payloadCodingEnable_r,
        .preambleBytes_r, .channelStep_r, .deviationStep_r, .phaseChangeFraction_r,
        .rxActive_r, .rxAbort_r);

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task endOfTest;
        if (numErrors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task apb(input logic wr, input logic [17:0] idx, input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Pulse of {rxStart, symbolTick, packetEnd}
    task strobe(input logic [2:0] m);
        {rxStart, symbolTick, packetEnd} <= m;
        @(posedge ref_clk);
        {rxStart, symbolTick, packetEnd} <= 3'h0;
        @(posedge ref_clk);
    endtask

    task rxRun(input int lim);
        strobe(3'h4);
        check(rxActive_r, 1'b1);
        n = 0;
        while (rxAbort_r !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    task automatic testRegs;
        logic [17:0] idx [6] = '{`RMCRT_IDX_MODEM, `RMCRT_IDX_SPACING, `RMCRT_IDX_DEVIATE,
                                 `RMCRT_IDX_RXTIME, `RMCRT_IDX_CHANNEL, `RMCRT_IDX_EVENT};
        logic [31:0] rst [6] = '{32'h0000_0022, 32'h0000_00f8, 32'h0000_0047, 32'h0000_0007,
                                 32'h0000_0000, 32'h0000_0800};
        logic [31:0] msk [6] = '{32'h0000_00f3, 32'h0000_00ff, 32'h0000_0077, 32'h0000_001f,
                                 32'h0000_00ff, 32'h0003_ffff};
        check(preambleBytes_r, 5'h04);
        check(payloadCodingEnable_r, 1'b0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, idx[i], 32'h0000_0000);
            check(rd, rst[i]);
            apb(1'b1, idx[i], 32'hffff_ffff);
            apb(1'b0, idx[i], 32'h0000_0000);
            check(rd, msk[i]);
        end
        apb(1'b0, 18'h0_df30, 32'h0000_0000);
        check(err, 1'b1);
        check(rd, 32'h0000_0000);
    endtask

    task automatic testFields;
        logic [4:0] pre [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18};
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `RMCRT_IDX_MODEM, {24'h0, c[0], c[2:0], 4'h0});
            repeat (2) @(posedge ref_clk);
            check(preambleBytes_r, pre[c]);
            check(payloadCodingEnable_r, c[0]);
        end
    endtask

    task automatic testSteps;
        logic [1:0] e [2] = '{2'h2, 2'h3};
        logic [7:0] m [2] = '{8'h10, 8'hff};
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `RMCRT_IDX_MODEM, {30'h0, e[i]});
            apb(1'b1, `RMCRT_IDX_SPACING, {24'h0, m[i]});
            apb(1'b1, `RMCRT_IDX_CHANNEL, {24'h0, m[i] ^ 8'h15});
            repeat (2) @(posedge ref_clk);
            check(channelStep_r, ((20'h100 + m[i]) * (m[i] ^ 8'h15)) << e[i]);
        end
        apb(1'b1, `RMCRT_IDX_DEVIATE, 32'h0000_0035);
        repeat (2) @(posedge ref_clk);
        check({phaseChangeFraction_r, deviationStep_r}, {3'h0, 11'h068});
        mskMode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check({phaseChangeFraction_r, deviationStep_r}, {3'h5, 11'h000});
        mskMode <= 1'b0;
    endtask

    task automatic testTimeout;
        logic [2:0] code [4] = '{3'h0, 3'h2, 3'h6, 3'h2};
        logic [1:0] res [4] = '{2'h0, 2'h0, 2'h0, 2'h1};
        int edges [4] = '{8, 2, 1, 32};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `RMCRT_IDX_EVENT, {14'h0, res[i], 16'h0047});
            apb(1'b1, `RMCRT_IDX_RXTIME, {29'h0, code[i]});
            rxRun(400);
            check(n >= 4 * edges[i] - 4 && n <= 4 * edges[i] + 10, 1'b1);
        end
    endtask

    task testQualifier;
        apb(1'b1, `RMCRT_IDX_EVENT, 32'h0000_0047);
        apb(1'b1, `RMCRT_IDX_RXTIME, 32'h0000_000a);
        preambleQualityReached <= 1'b1;
        rxRun(60);
        check(n, 60);
        check(rxActive_r, 1'b1);
        strobe(3'h1);
        check(rxActive_r, 1'b0);
        apb(1'b1, `RMCRT_IDX_RXTIME, 32'h0000_0002);
        rxRun(60);
        check(n < 60, 1'b1);
        apb(1'b0, `RMCRT_IDX_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_0009);
        preambleQualityReached <= 1'b0;
        apb(1'b1, `RMCRT_IDX_RXTIME, 32'h0000_0007);
        rxRun(300);
        check(n, 300);
        check(rxActive_r, 1'b1);
        syncFound <= 1'b1;
        @(posedge ref_clk);
        syncFound <= 1'b0;
        strobe(3'h1);
        check(rxActive_r, 1'b0);
    endtask

    task testCarrier;
        apb(1'b1, `RMCRT_IDX_RXTIME, 32'h0000_0017);
        rxRun(0);
        a = aborts;
        strobe(3'h2);
        repeat (2) @(posedge ref_clk);
        check(aborts - a, 1);
        askMode <= 1'b1;
        rxRun(0);
        a = aborts;
        repeat (7) strobe(3'h2);
        check(aborts - a, 0);
        strobe(3'h2);
        repeat (2) @(posedge ref_clk);
        check(aborts - a, 1);
        carrierSense <= 1'b1;
        rxRun(0);
        a = aborts;
        repeat (8) strobe(3'h2);
        check(aborts - a, 0);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        testRegs;
        testFields;
        testSteps;
        testTimeout;
        testQualifier;
        testCarrier;
        endOfTest;
    end
endmodule
